//--- shared/fshlt_pkg.sv
// Constants for the transmit sync header stream and parity logic.
// Assumes one 64-bit scrambled payload block per accepted transfer.
package fshlt_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] FSHLT_OFS_CTRL   = 12'h000;
   localparam logic [11:0] FSHLT_OFS_STATUS = 12'h004;
   localparam logic [11:0] FSHLT_OFS_PARITY = 12'h008;
   localparam logic [11:0] FSHLT_OFS_STREAM = 12'h00C;
   localparam logic [11:0] FSHLT_OFS_MBCNT  = 12'h010;
   localparam int          FSHLT_AW         = 12;
   // Control fields
   localparam int          FSHLT_CTRL_EN_BIT = 0;
   localparam int          FSHLT_CTRL_PE_LSB = 4;
   localparam int          FSHLT_PE_W        = 4;
   localparam logic [31:0] FSHLT_CTRL_RST    = 32'h0000_0000;
   // Status fields
   localparam int          FSHLT_ST_RUN_BIT  = 0;
   localparam int          FSHLT_ST_POS_LSB  = 8;
   localparam int          FSHLT_ST_PD_BIT   = 1;
   // Payload and parity geometry
   localparam int          FSHLT_BLK_W      = 64;
   localparam int          FSHLT_PAR_W      = 26;
   localparam logic [25:0] FSHLT_POLY_LOW   = 26'h022_0211;
   localparam int          FSHLT_SH_W       = 32;
   localparam int          FSHLT_POS_W      = 5;
   localparam logic [4:0]  FSHLT_POS_LAST   = 5'h1F;
   localparam int          FSHLT_PAR_HI_N   = 22;
   localparam int          FSHLT_EXT_MULTIBLOCK_END_FLAG_POS  = 22;
   localparam int          FSHLT_P3_POS     = 23;
   localparam int          FSHLT_P2_POS     = 24;
   localparam int          FSHLT_PILOT_LSB  = 27;
   localparam logic [4:0]  FSHLT_PILOT      = 5'h10;
   localparam logic        FSHLT_EXT_MULTIBLOCK_END_FLAG_VAL  = 1'b1;
   // Sync header codes, first transmitted bit on the left
   localparam logic [1:0]  FSHLT_SH_ONE     = 2'h1;
   localparam logic [1:0]  FSHLT_SH_ZERO    = 2'h2;
   localparam int          FSHLT_MBCNT_W    = 16;
   typedef enum logic [0:0] {FSHLT_OFF, FSHLT_RUN} fshlt_state_t;
endpackage : fshlt_pkg

//--- core/fshlt_parity_gen.sv
// Serial parity register for the shortened cyclic code, 64 bits per step.
// Assumes the caller raises last on the 32nd block of each multiblock.
`timescale 1ns/10ps
`default_nettype none
module fshlt_parity_gen
   import fshlt_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   input  wire logic                   clr,
   input  wire logic                   step,
   input  wire logic                   last,
   input  wire logic [FSHLT_BLK_W-1:0] din,
   output logic      [FSHLT_PAR_W-1:0] parity_r
);
   logic [FSHLT_PAR_W-1:0] acc_r;
   logic [FSHLT_PAR_W-1:0] acc_nxt;

   // Bit 63 goes first, one register shift per payload bit
   function automatic logic [FSHLT_PAR_W-1:0] fshlt_shift64(input logic [FSHLT_PAR_W-1:0] s,
                                                           input logic [FSHLT_BLK_W-1:0] d);
      logic [FSHLT_PAR_W-1:0] t;
      logic                   fb;
      t = s;
      for (int i = FSHLT_BLK_W - 1; i >= 0; i--) begin
         fb = d[i] ^ t[FSHLT_PAR_W-1];
         t  = {t[FSHLT_PAR_W-2:0], 1'b0} ^ (fb ? FSHLT_POLY_LOW : '0);
      end
      return t;
   endfunction : fshlt_shift64

   assign acc_nxt = fshlt_shift64(acc_r, din);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         acc_r    <= '0;
         parity_r <= '0;
      end else if (clr) begin
         acc_r    <= '0;
         parity_r <= '0;
      end else if (step) begin
         // Cells restart from zero for the next multiblock
         acc_r <= last ? '0 : acc_nxt;
         if (last) begin
            parity_r <= acc_nxt;
         end
      end
   end
endmodule : fshlt_parity_gen
`default_nettype wire

//--- core/fshlt_link_tx.sv
// Transmit sync header stream builder with parity, enable gating and APB registers.
// Assumes a scrambled 64-bit payload source with valid/ready and an APB master.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Each 32-block 2048-bit multiblock feeds the 26-bit parity generator.
// - Parity of one multiblock is sent in the next multiblock's stream.
// - First-bit error detection and correction takes at least 58 blocks.
// - Stream holds parity 25..4, end flag at 22, parity 3, parity 2..0.
// - Stream positions 27..30 are zero and 31 is one: the pilot.
// - End flag is one only in the last multiblock of an extended multiblock.
// - Generator polynomial x^26+x^21+x^17+x^9+x^4+1, shortened 2074/2048 code.
// - Only payload bits feed parity; cells cleared before each multiblock.
// - Every block starts with a two-bit sync header holding a transition.
// - Pre-emphasis comes from a setting; larger values mean stronger emphasis.
// - Enable low holds the link in reset, powers down serializers, gates clocks.
// - Stream bit one is sent as header 01, zero as header 10.
// - One multiblock per extended multiblock, so the end flag is always set.
module fshlt_link_tx
   import fshlt_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [FSHLT_AW-1:0]    paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic                        pready,
   output logic      [31:0]            prdata,
   output logic                        pslverr,
   input  wire logic [FSHLT_BLK_W-1:0] blk_data,
   input  wire logic                   blk_valid,
   output logic                        blk_ready,
   output logic      [FSHLT_BLK_W+1:0] tx_block,
   output logic                        tx_valid,
   output logic                        tx_mb_start,
   output logic      [FSHLT_PE_W-1:0]  serializer_preemphasis_level,
   output logic                        serdes_powerdown,
   output logic                        link_clk_en,
   output logic                        link_reset_n
);
   // Sync header stream in position order, position 0 sent first
   function automatic logic [FSHLT_SH_W-1:0] fshlt_stream(input logic [FSHLT_PAR_W-1:0] p,
                                                         input logic                   ext_multiblock_end_flag);
      logic [FSHLT_SH_W-1:0] s;
      s = '0;
      for (int i = 0; i < FSHLT_PAR_HI_N; i++) begin
         s[i] = p[FSHLT_PAR_W-1-i];
      end
      s[FSHLT_EXT_MULTIBLOCK_END_FLAG_POS] = ext_multiblock_end_flag;
      s[FSHLT_P3_POS]    = p[3];
      for (int i = 0; i < 3; i++) begin
         s[FSHLT_P2_POS+i] = p[2-i];
      end
      // Pilot constant holds position 31 in its top bit, so bit i lands at position 27+i
      for (int i = 0; i < 5; i++) begin
         s[FSHLT_PILOT_LSB+i] = FSHLT_PILOT[i];
      end
      return s;
   endfunction : fshlt_stream

   // Register word read-back selection, shared by all offsets
   function automatic logic fshlt_hit(input logic [FSHLT_AW-1:0] a, input logic [FSHLT_AW-1:0] ofs);
      return (a[FSHLT_AW-1:2] == ofs[FSHLT_AW-1:2]);
   endfunction : fshlt_hit

   fshlt_state_t             state_r;
   fshlt_state_t             state_nxt;
   logic [31:0]              ctrl_r;
   logic [31:0]              ctrl_nxt;
   logic                     pready_r;
   logic [31:0]              prdata_r;
   logic                     pslverr_r;
   logic                     blk_ready_r;
   logic [FSHLT_BLK_W+1:0]   tx_block_r;
   logic                     tx_valid_r;
   logic                     tx_mb_start_r;
   logic [FSHLT_PE_W-1:0]    pe_r;
   logic                     pd_r;
   logic                     clk_en_r;
   logic                     lrst_n_r;
   logic [FSHLT_POS_W-1:0]   pos_r;
   logic [FSHLT_SH_W-1:0]    stream_r;
   logic [FSHLT_MBCNT_W-1:0] mbcnt_r;
   logic [FSHLT_PAR_W-1:0]   parity_word;

   // APB decode
   wire        apb_acc    = psel & penable;
   wire        apb_done   = apb_acc & pready_r;
   wire        hit_ctrl   = fshlt_hit(paddr, FSHLT_OFS_CTRL);
   wire        hit_status = fshlt_hit(paddr, FSHLT_OFS_STATUS);
   wire        hit_parity = fshlt_hit(paddr, FSHLT_OFS_PARITY);
   wire        hit_stream = fshlt_hit(paddr, FSHLT_OFS_STREAM);
   wire        hit_mbcnt  = fshlt_hit(paddr, FSHLT_OFS_MBCNT);
   wire        hit_any    = hit_ctrl | hit_status | hit_parity | hit_stream | hit_mbcnt;
   wire        ctrl_wr    = apb_done & pwrite & hit_ctrl;
   wire        bad_wr     = pwrite & ~hit_ctrl;

   // Byte lanes honoured on the control word
   always_comb begin
      ctrl_nxt = ctrl_r;
      for (int b = 0; b < 4; b++) begin
         if (pstrb[b]) begin
            ctrl_nxt[8*b +: 8] = pwdata[8*b +: 8];
         end
      end
   end

   wire        en_bit     = ctrl_r[FSHLT_CTRL_EN_BIT];
   wire [FSHLT_PE_W-1:0] pe_set = ctrl_r[FSHLT_CTRL_PE_LSB +: FSHLT_PE_W];

   // Link datapath decode
   wire        running    = (state_r == FSHLT_RUN);
   wire        accept     = running & blk_valid & blk_ready_r;
   wire        mb_first   = (pos_r == '0);
   wire        mb_last    = (pos_r == FSHLT_POS_LAST);
   // With one multiblock per extended multiblock every multiblock is the last one
   wire        ext_multiblock_end_flag      = FSHLT_EXT_MULTIBLOCK_END_FLAG_VAL;
   wire [FSHLT_SH_W-1:0] new_stream = fshlt_stream(parity_word, ext_multiblock_end_flag);
   wire [FSHLT_SH_W-1:0] cur_stream = mb_first ? new_stream : stream_r;
   wire        sh_bit     = cur_stream[pos_r];
   wire [1:0]  sh_code    = sh_bit ? FSHLT_SH_ONE : FSHLT_SH_ZERO;

   wire [31:0] status_word = {16'h0000, 3'h0, pos_r, 6'h00, pd_r, running};
   wire [31:0] rd_word = hit_ctrl   ? ctrl_r :
                         hit_status ? status_word :
                         hit_parity ? {6'h00, parity_word} :
                         hit_stream ? stream_r :
                         hit_mbcnt  ? {16'h0000, mbcnt_r} : 32'h0000_0000;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FSHLT_OFF: begin
            if (en_bit) begin
               state_nxt = FSHLT_RUN;
            end
         end
         FSHLT_RUN: begin
            if (!en_bit) begin
               state_nxt = FSHLT_OFF;
            end
         end
         default: state_nxt = FSHLT_OFF;
      endcase
   end

   // One wait state so that read data leave a flip-flop
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= apb_acc & ~pready_r;
         prdata_r  <= (apb_acc & ~pready_r & ~pwrite) ? rd_word : 32'h0000_0000;
         pslverr_r <= apb_acc & ~pready_r & (~hit_any | bad_wr);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= FSHLT_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Enable gating and serializer controls
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_r  <= FSHLT_OFF;
         pd_r     <= 1'b1;
         clk_en_r <= 1'b0;
         lrst_n_r <= 1'b0;
         pe_r     <= '0;
      end else begin
         state_r  <= state_nxt;
         pd_r     <= ~en_bit;
         clk_en_r <= en_bit;
         lrst_n_r <= en_bit;
         pe_r     <= pe_set;
      end
   end

   // Block position, stream latch and block output
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pos_r         <= '0;
         stream_r      <= '0;
         mbcnt_r       <= '0;
         blk_ready_r   <= 1'b0;
         tx_block_r    <= '0;
         tx_valid_r    <= 1'b0;
         tx_mb_start_r <= 1'b0;
      end else if (!running || !en_bit) begin
         // Held in reset while disabled
         pos_r         <= '0;
         stream_r      <= '0;
         mbcnt_r       <= '0;
         blk_ready_r   <= running & en_bit;
         tx_block_r    <= '0;
         tx_valid_r    <= 1'b0;
         tx_mb_start_r <= 1'b0;
      end else begin
         blk_ready_r   <= 1'b1;
         tx_valid_r    <= accept;
         tx_mb_start_r <= accept & mb_first;
         if (accept) begin
            // Header leads the payload; payload goes to parity untouched
            tx_block_r <= {sh_code, blk_data};
            pos_r      <= pos_r + 5'h01;
            if (mb_first) begin
               stream_r <= new_stream;
            end
            if (mb_last) begin
               mbcnt_r <= mbcnt_r + 16'h0001;
            end
         end
      end
   end

   fshlt_parity_gen u_parity (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .clr      (~running | ~en_bit),
      .step     (accept),
      .last     (mb_last),
      .din      (blk_data),
      .parity_r (parity_word)
   );

   assign pready                       = pready_r;
   assign prdata                       = prdata_r;
   assign pslverr                      = pslverr_r;
   assign blk_ready                    = blk_ready_r;
   assign tx_block                     = tx_block_r;
   assign tx_valid                     = tx_valid_r;
   assign tx_mb_start                  = tx_mb_start_r;
   assign serializer_preemphasis_level = pe_r;
   assign serdes_powerdown             = pd_r;
   assign link_clk_en                  = clk_en_r;
   assign link_reset_n                 = lrst_n_r;
endmodule : fshlt_link_tx
`default_nettype wire

//--- dv/fshlt_link_tx_assertions.sv
// Checker for the sync header stream builder, bound to its top ports.
// Assumes a single clk_sys domain with nrst as its asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module fshlt_link_tx_chk
   import fshlt_pkg::*;
(
   input wire logic                   clk_sys,
   input wire logic                   nrst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [FSHLT_BLK_W-1:0] blk_data,
   input wire logic                   blk_valid,
   input wire logic                   blk_ready,
   input wire logic [FSHLT_BLK_W+1:0] tx_block,
   input wire logic                   tx_valid,
   input wire logic                   tx_mb_start,
   input wire logic                   serdes_powerdown,
   input wire logic                   link_clk_en,
   input wire logic                   link_reset_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Position of the block now on the line, rebuilt from the start pulse
   logic [4:0] pos_r;
   wire  [4:0] cur = tx_mb_start ? 5'h00 : pos_r;
   wire  [1:0] hdr = tx_block[65:64];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) pos_r <= 5'h00;
      else if (tx_valid) pos_r <= cur + 5'h01;
   end
   chk_pilot_zero: assert property (tx_valid && cur >= 5'd27 && cur <= 5'd30 |-> hdr == FSHLT_SH_ZERO)
      else $error("pilot zero bit wrong");
   chk_pilot_one: assert property (tx_valid && cur == 5'd31 |-> hdr == FSHLT_SH_ONE)
      else $error("pilot end bit wrong");
   chk_end_flag: assert property (tx_valid && cur == 5'd22 |-> hdr == FSHLT_SH_ONE)
      else $error("end flag not set");
   chk_sync_trans: assert property (tx_valid |-> hdr[1] != hdr[0])
      else $error("sync header without transition");
   chk_tx_latency: assert property (blk_valid && blk_ready |=> tx_valid && tx_block[63:0] == $past(blk_data))
      else $error("block not sent one cycle after accept");
   chk_no_spurious: assert property (tx_valid |-> $past(blk_valid && blk_ready))
      else $error("block sent without accept");
   chk_off_state: assert property (!link_reset_n |-> serdes_powerdown && !link_clk_en && !blk_ready)
      else $error("link active while held in reset");
   chk_apb_wait: assert property (psel && penable && !$past(penable) |-> ##1 pready ##1 !pready)
      else $error("apb answer timing wrong");
   chk_err_pready: assert property (pslverr |-> pready)
      else $error("error without ready");
   cover property (tx_mb_start);
   cover property (pslverr);
   cover property ($rose(link_clk_en));
endmodule : fshlt_link_tx_chk
bind fshlt_link_tx fshlt_link_tx_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .blk_data(blk_data), .blk_valid(blk_valid), .blk_ready(blk_ready),
   .tx_block(tx_block), .tx_valid(tx_valid), .tx_mb_start(tx_mb_start), .serdes_powerdown(serdes_powerdown),
   .link_clk_en(link_clk_en), .link_reset_n(link_reset_n));
`default_nettype wire

//--- dv/fshlt_rx_model.sv
// Receiving logic device: decodes the sync header stream and checks parity.
// Assumes it sees every transmitted block; cleared while the link is held in reset.
`timescale 1ns/10ps
`default_nettype none
module fshlt_rx_model
   import fshlt_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   input  wire logic                   link_reset_n,
   input  wire logic [FSHLT_BLK_W+1:0] tx_block,
   input  wire logic                   tx_valid,
   input  wire logic                   tx_mb_start,
   output logic      [FSHLT_PAR_W-1:0] syndrome_r,
   output logic      [FSHLT_PAR_W-1:0] par_prev_r,
   output logic      [4:0]             pilot_r,
   output logic                        flag_r,
   output logic                        mb_done_r,
   output logic      [15:0]            mb_cnt_r
);
   logic [25:0] acc_r;
   logic [31:0] st_r;
   logic [4:0]  pos_r;
   // Bit-serial on purpose: slow, but independent of the wide design form
   function automatic logic [25:0] crc64(logic [25:0] s, logic [63:0] d);
      logic fb;
      for (int i = 63; i >= 0; i--) begin
         fb = d[i] ^ s[25];
         s  = {s[24:0], 1'b0} ^ (fb ? FSHLT_POLY_LOW : 26'h000_0000);
      end
      return s;
   endfunction : crc64
   always @(posedge clk_sys or negedge nrst) begin : rx_proc
      logic [4:0]  p;
      logic [31:0] st;
      logic [25:0] a;
      logic [25:0] rp;
      mb_done_r <= 1'b0;
      if (!nrst || !link_reset_n) begin
         // Link reset restarts the local multiblock timing before realignment
         {acc_r, st_r, pos_r, syndrome_r, par_prev_r, pilot_r, flag_r, mb_cnt_r} <= '0;
      end else if (tx_valid) begin
         p     = tx_mb_start ? 5'h00 : pos_r + 5'h01;
         st    = st_r;
         st[p] = (tx_block[65:64] == 2'h1);
         a     = crc64((p == 5'h00) ? 26'h000_0000 : acc_r, tx_block[63:0]);
         pos_r <= p;
         st_r  <= st;
         acc_r <= a;
         if (p == 5'h1F) begin
            for (int i = 0; i < 22; i++) rp[25-i] = st[i];
            rp[3] = st[23];
            for (int j = 0; j < 3; j++) rp[2-j] = st[24+j];
            // Nonzero syndrome would drive burst location and correction
            syndrome_r <= rp ^ par_prev_r;
            par_prev_r <= a;
            pilot_r    <= {st[27], st[28], st[29], st[30], st[31]};
            flag_r     <= st[22];
            // Multiblock edge doubles as the buffer release point
            mb_done_r  <= 1'b1;
            mb_cnt_r   <= mb_cnt_r + 16'h0001;
         end
      end
   end
endmodule : fshlt_rx_model
`default_nettype wire

//--- dv/test_fec_sync_header_link_tx.sv
// Self-checking bench: APB tasks, a block source and the receiving model.
// Assumes the design answers APB with one wait state as its note states.
`timescale 1ns/10ps
`default_nettype none
module test_fec_sync_header_link_tx;
   import fshlt_pkg::*;
   logic        clk_sys, nrst, psel, penable, pwrite, blk_valid, pready, pslverr, blk_ready, er;
   logic        tx_valid, tx_mb_start, serdes_powerdown, link_clk_en, link_reset_n, mb_done, flag;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, pe;
   logic [63:0] blk_data;
   logic [65:0] tx_block;
   logic [25:0] syndrome, par_prev;
   logic [4:0]  pilot;
   logic [15:0] mb_cnt;
   int          bad_count, tests_run, blk_left;
   fshlt_link_tx dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .blk_data(blk_data), .blk_valid(blk_valid), .blk_ready(blk_ready), .tx_block(tx_block),
      .tx_valid(tx_valid), .tx_mb_start(tx_mb_start), .serializer_preemphasis_level(pe),
      .serdes_powerdown(serdes_powerdown), .link_clk_en(link_clk_en), .link_reset_n(link_reset_n));
   fshlt_rx_model rx (.clk_sys(clk_sys), .nrst(nrst), .link_reset_n(link_reset_n), .tx_block(tx_block),
      .tx_valid(tx_valid), .tx_mb_start(tx_mb_start), .syndrome_r(syndrome), .par_prev_r(par_prev),
      .pilot_r(pilot), .flag_r(flag), .mb_done_r(mb_done), .mb_cnt_r(mb_cnt));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Streams n multiblocks and waits until the receiver has seen them all
   task automatic run_mb(input int n);
      int w;
      blk_left <= 32 * n;
      blk_valid <= 1'b1;
      w = 0;
      while (mb_cnt !== 16'(n) && w < 2000) begin @(posedge clk_sys); w++; end
      if (w >= 2000) bad_count++;
   endtask : run_mb
   always @(posedge clk_sys) if (blk_valid && blk_ready) begin
      blk_data <= blk_data + 64'h9E37_79B9_7F4A_7C15;
      if (blk_left == 1) blk_valid <= 1'b0;
      blk_left <= blk_left - 1;
   end
   always @(posedge clk_sys) if (mb_done) begin
      chk({6'h00, syndrome}, 32'h0);
      chk({27'h0, pilot}, 32'h1);
      chk({31'h0, flag}, 32'h1);
   end
   initial begin
      #(40 * 5000);
      bad_count++;
      finish_test();
   end
   initial begin
      {nrst, psel, penable, pwrite, blk_valid, paddr, pwdata} = '0;
      {tests_run, bad_count, blk_left} = '0;
      pstrb = 4'hF;
      blk_data = 64'h0123_4567_89AB_CDEF;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      apb(1'b0, FSHLT_OFS_CTRL, 32'h0);
      chk(rd, FSHLT_CTRL_RST);
      apb(1'b0, FSHLT_OFS_STATUS, 32'h0);
      chk(rd, 32'h2);
      chk({link_clk_en, link_reset_n, serdes_powerdown}, 32'h1);
      apb(1'b0, 12'h020, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      apb(1'b1, FSHLT_OFS_PARITY, 32'hFFFF_FFFF);
      chk(er, 32'h1);
      $display("test registers done");
      apb(1'b1, FSHLT_OFS_CTRL, 32'h50);
      apb(1'b1, FSHLT_OFS_CTRL, 32'h51);
      repeat (2) @(posedge clk_sys);
      chk({link_clk_en, link_reset_n, serdes_powerdown, pe}, 32'h65);
      run_mb(3);
      apb(1'b0, FSHLT_OFS_PARITY, 32'h0);
      chk(rd, {6'h00, par_prev});
      apb(1'b0, FSHLT_OFS_MBCNT, 32'h0);
      chk(rd, 32'h3);
      $display("test stream done");
      apb(1'b1, FSHLT_OFS_CTRL, 32'hA0);
      repeat (2) @(posedge clk_sys);
      chk({blk_ready, link_clk_en, link_reset_n, serdes_powerdown}, 32'h1);
      apb(1'b1, FSHLT_OFS_CTRL, 32'hA1);
      repeat (2) @(posedge clk_sys);
      chk({28'h0, pe}, 32'hA);
      run_mb(2);
      $display("test restart done");
      finish_test();
   end
endmodule : test_fec_sync_header_link_tx
`default_nettype wire
